// >>> design/ascd_pkg.sv
// Notes on behaviour
// RULE_01 - All-bank checksum adds every bank byte, keeps low eight bits, drops carry.
// RULE_02 - All-bank checksum masks no bits; every stored bit contributes.
// RULE_03 - Combined self calibration updates both offset and gain registers.
// RULE_04 - Offset self calibration updates only the offset register.
// RULE_05 - Gain self calibration updates only the gain register.
// RULE_06 - System offset calibration stores compensating offset from zero input.
// RULE_07 - System gain calibration stores compensating gain from reference input.
// RULE_08 - Synchronise command realigns conversion and ready timing to serial clock edge.
// RULE_09 - Sleep command enters sleep until the wakeup command arrives.
// RULE_10 - Host keeps serial clock idle during sleep except to send wakeup.
// RULE_11 - Wakeup command leaves sleep and resumes normal operation.
// RULE_12 - Reset command returns configuration registers to power-up values.
// RULE_13 - Reset command also ends continuous data output mode.
// RULE_14 - Reset command leaves memory banks unchanged.
// RULE_15 - Undefined rows and unassigned codes are reserved and define nothing.
// RULE_16 - Continuous mode outputs each result on ready until stop or reset.
// RULE_17 - Reserved opcodes change nothing; decoder waits for the next byte.
package ascd_pkg;
    localparam logic [7:0] OP_RDATAC = 8'h03;
    localparam logic [7:0] OP_STOPC = 8'h0f;
    localparam logic [7:0] OP_ALL_BANK_CSUM = 8'he8;
    localparam logic [7:0] OP_SELF_CAL_BOTH = 8'hf0;
    localparam logic [7:0] OP_SELF_CAL_OFFSET = 8'hf1;
    localparam logic [7:0] OP_SELF_CAL_GAIN = 8'hf2;
    localparam logic [7:0] OP_SYSTEM_CAL_OFFSET = 8'hf3;
    localparam logic [7:0] OP_SYSTEM_CAL_GAIN = 8'hf4;
    localparam logic [7:0] OP_WAKEUP = 8'hfb;
    localparam logic [7:0] OP_DSYNC = 8'hfc;
    localparam logic [7:0] OP_SLEEP = 8'hfd;
    localparam logic [7:0] OP_RESET = 8'hfe;
    localparam int BANKS = 8;
    localparam int BANK_BYTES = 16;
    localparam logic [7:0] CSUM_RST = 8'h00;
    localparam logic [2:0] CAL_NONE = 3'h0;

    // Calibration request: which correction registers the engine refreshes.
    typedef struct packed {
        logic go;
        logic offset;
        logic gain;
        logic system;
    } ascd_cal_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SUM = 4'b0010,
        ST_SLEEP = 4'b0100,
        ST_DONE = 4'b1000
    } ascd_state_t;
endpackage : ascd_pkg

// >>> design/ascd_byte_rx.sv
`timescale 1ns/1ps
// Serial receiver: samples the link clock on clk_i and shifts MSB first on rising edges.
module ascd_byte_rx
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic din_i,
    output logic byte_vld_o,
    output logic [7:0] byte_o,
    output logic sclk_rise_o
);
    logic [2:0] sclk_s_r;
    logic [1:0] cs_s_r;
    logic [1:0] din_s_r;
    logic [2:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic vld_r, vld_nxt;
    logic rise;

    assign rise = sclk_s_r[1] & ~sclk_s_r[2];

    always_comb
    begin
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        vld_nxt = 1'b0;
        if (cs_s_r[1])
        begin
            cnt_nxt = 3'h0;
        end
        else if (rise)
        begin
            sh_nxt = {sh_r[6:0], din_s_r[1]};
            cnt_nxt = cnt_r + 3'h1;
            vld_nxt = (cnt_r == 3'h7);
        end
    end

    always_ff @(posedge clk_i)
    begin
        sclk_s_r <= {sclk_s_r[1:0], sclk_i};
        cs_s_r <= {cs_s_r[0], cs_n_i};
        din_s_r <= {din_s_r[0], din_i};
        if (srst_i)
        begin
            cnt_r <= 3'h0;
            sh_r <= 8'h00;
            vld_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            vld_r <= vld_nxt;
        end
    end

    assign byte_vld_o = vld_r;
    assign byte_o = sh_r;
    assign sclk_rise_o = rise;
endmodule : ascd_byte_rx

// >>> design/ascd_decoder.sv
`timescale 1ns/1ps
module ascd_decoder
#(
    parameter int NUM_BANKS = ascd_pkg::BANKS,
    parameter int BYTES_PER_BANK = ascd_pkg::BANK_BYTES
)
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic din_i,
    input wire logic bank_we_i,
    input wire logic [$clog2(NUM_BANKS*BYTES_PER_BANK)-1:0] bank_waddr_i,
    input wire logic [7:0] bank_wdata_i,
    input wire logic cal_done_i,
    output ascd_pkg::ascd_cal_t cal_req_o,
    output logic [7:0] checksum_o,
    output logic checksum_vld_o,
    output logic sync_o,
    output logic sleep_o,
    output logic cont_mode_o,
    output logic cfg_reset_o,
    output logic cal_busy_o
);
    import ascd_pkg::*;

    localparam int DEPTH = NUM_BANKS * BYTES_PER_BANK;
    localparam int AW = $clog2(DEPTH);

    ////////////////////////////////////////////////////////////////////////////
    logic byte_vld;
    logic [7:0] byte_d;
    logic sclk_rise;

    ascd_byte_rx u_rx
    (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .sclk_i(sclk_i),
        .cs_n_i(cs_n_i),
        .din_i(din_i),
        .byte_vld_o(byte_vld),
        .byte_o(byte_d),
        .sclk_rise_o(sclk_rise)
    );

    // Bank storage is never cleared, so the reset command keeps it intact.
    logic [7:0] bank_mem [DEPTH]; // [RULE_14]
    always_ff @(posedge clk_i)
    begin
        if (bank_we_i)
        begin
            bank_mem[bank_waddr_i] <= bank_wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    ascd_state_t st_r, st_nxt;
    logic [AW-1:0] idx_r, idx_nxt;
    logic [7:0] acc_r, acc_nxt;
    logic [7:0] csum_r, csum_nxt;
    logic csv_r, csv_nxt;
    ascd_cal_t cal_r, cal_nxt;
    logic busy_r, busy_nxt;
    logic sync_r, sync_nxt;
    logic cont_r, cont_nxt;
    logic cfgrst_r, cfgrst_nxt;
    logic slp_r, slp_nxt;

    always_comb
    begin
        st_nxt = st_r;
        idx_nxt = idx_r;
        acc_nxt = acc_r;
        csum_nxt = csum_r;
        csv_nxt = 1'b0;
        cal_nxt = '0;
        busy_nxt = busy_r & ~cal_done_i;
        // The sync level holds until the first serial clock rise after the command. [RULE_08]
        sync_nxt = sync_r & ~sclk_rise;
        cont_nxt = cont_r;
        cfgrst_nxt = 1'b0;
        unique case (st_r)
            ST_IDLE:
            begin
                if (byte_vld)
                begin
                    // Any code not matched below falls through untouched. [RULE_15] [RULE_17]
                    unique case (byte_d)
                        OP_ALL_BANK_CSUM:
                        begin
                            idx_nxt = '0;
                            acc_nxt = CSUM_RST;
                            st_nxt = ST_SUM;
                        end
                        OP_SELF_CAL_BOTH:
                        begin
                            cal_nxt = '{go: 1'b1, offset: 1'b1, gain: 1'b1, system: 1'b0}; // [RULE_03]
                            busy_nxt = 1'b1;
                        end
                        OP_SELF_CAL_OFFSET:
                        begin
                            cal_nxt = '{go: 1'b1, offset: 1'b1, gain: 1'b0, system: 1'b0}; // [RULE_04]
                            busy_nxt = 1'b1;
                        end
                        OP_SELF_CAL_GAIN:
                        begin
                            cal_nxt = '{go: 1'b1, offset: 1'b0, gain: 1'b1, system: 1'b0}; // [RULE_05]
                            busy_nxt = 1'b1;
                        end
                        OP_SYSTEM_CAL_OFFSET:
                        begin
                            cal_nxt = '{go: 1'b1, offset: 1'b1, gain: 1'b0, system: 1'b1}; // [RULE_06]
                            busy_nxt = 1'b1;
                        end
                        OP_SYSTEM_CAL_GAIN:
                        begin
                            cal_nxt = '{go: 1'b1, offset: 1'b0, gain: 1'b1, system: 1'b1}; // [RULE_07]
                            busy_nxt = 1'b1;
                        end
                        OP_DSYNC: sync_nxt = 1'b1;
                        OP_SLEEP: st_nxt = ST_SLEEP; // [RULE_09]
                        OP_RDATAC: cont_nxt = 1'b1; // [RULE_16]
                        OP_STOPC: cont_nxt = 1'b0; // [RULE_16]
                        OP_RESET:
                        begin
                            cfgrst_nxt = 1'b1; // [RULE_12]
                            cont_nxt = 1'b0; // [RULE_13]
                        end
                        default: ;
                    endcase
                end
            end
            ST_SUM:
            begin
                // Plain 8-bit add: carry discarded, no bit masked. [RULE_01] [RULE_02]
                acc_nxt = acc_r + bank_mem[idx_r];
                idx_nxt = idx_r + AW'(1);
                if (idx_r == AW'(DEPTH - 1))
                begin
                    st_nxt = ST_DONE;
                end
            end
            ST_DONE:
            begin
                csum_nxt = acc_r;
                csv_nxt = 1'b1;
                st_nxt = ST_IDLE;
            end
            ST_SLEEP:
            begin
                // Relies on the host keeping the link clock idle except for wakeup. [RULE_10]
                if (byte_vld && byte_d == OP_WAKEUP)
                begin
                    st_nxt = ST_IDLE; // [RULE_11]
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
        slp_nxt = (st_nxt == ST_SLEEP); // [RULE_09]
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            st_r <= ST_IDLE;
            idx_r <= '0;
            acc_r <= CSUM_RST;
            csum_r <= CSUM_RST;
            csv_r <= 1'b0;
            cal_r <= '0;
            busy_r <= 1'b0;
            sync_r <= 1'b0;
            cont_r <= 1'b0;
            cfgrst_r <= 1'b0;
            slp_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            idx_r <= idx_nxt;
            acc_r <= acc_nxt;
            csum_r <= csum_nxt;
            csv_r <= csv_nxt;
            cal_r <= cal_nxt;
            busy_r <= busy_nxt;
            sync_r <= sync_nxt;
            cont_r <= cont_nxt;
            cfgrst_r <= cfgrst_nxt;
            slp_r <= slp_nxt;
        end
    end

    assign cal_req_o = cal_r;
    assign checksum_o = csum_r;
    assign checksum_vld_o = csv_r;
    assign sync_o = sync_r;
    assign sleep_o = slp_r;
    assign cont_mode_o = cont_r;
    assign cfg_reset_o = cfgrst_r;
    assign cal_busy_o = busy_r;

    ////////////////////////////////////////////////////////////////////////////
    sequence sum_walk_s;
        (st_r == ST_SUM) [*8];
    endsequence

    csum_start_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_01]
        (byte_vld && st_r == ST_IDLE && byte_d == OP_ALL_BANK_CSUM) |=> sum_walk_s)
        else $error("checksum walk did not start");
    // One cycle to enter the walk, one per bank byte, and one to latch and publish the total.
    csum_done_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_01]
        (byte_vld && st_r == ST_IDLE && byte_d == OP_ALL_BANK_CSUM) |-> ##130 csv_r)
        else $error("checksum not published");
    cal_both_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_03]
        (byte_vld && st_r == ST_IDLE && byte_d == OP_SELF_CAL_BOTH) |=> (cal_r.offset && cal_r.gain && busy_r))
        else $error("combined calibration wrong");
    cal_off_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_04]
        (byte_vld && st_r == ST_IDLE && byte_d == OP_SELF_CAL_OFFSET) |=> (cal_r.go && !cal_r.gain && !cal_r.system))
        else $error("offset calibration wrong");
    cal_gain_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_05]
        (byte_vld && st_r == ST_IDLE && byte_d == OP_SELF_CAL_GAIN) |=> (cal_r.go && !cal_r.offset))
        else $error("gain calibration wrong");
    sys_off_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_06]
        (byte_vld && st_r == ST_IDLE && byte_d == OP_SYSTEM_CAL_OFFSET) |=> (cal_r.system && cal_r.offset))
        else $error("system offset calibration wrong");
    sys_gain_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_07]
        (byte_vld && st_r == ST_IDLE && byte_d == OP_SYSTEM_CAL_GAIN) |=> (cal_r.system && cal_r.gain))
        else $error("system gain calibration wrong");
    sleep_enter_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_09]
        (byte_vld && st_r == ST_IDLE && byte_d == OP_SLEEP) |=> ##1 slp_r)
        else $error("sleep not entered");
    wake_exit_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_11]
        (byte_vld && st_r == ST_SLEEP && byte_d == OP_WAKEUP) |=> ##1 !slp_r)
        else $error("wakeup not honoured");
    reset_cmd_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_13]
        (byte_vld && st_r == ST_IDLE && byte_d == OP_RESET) |=> (cfgrst_r && !cont_r))
        else $error("reset command incomplete");
    cont_stop_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_16]
        (byte_vld && st_r == ST_IDLE && byte_d == OP_STOPC) |=> !cont_r)
        else $error("continuous mode not stopped");
    reserved_op_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_17]
        (byte_vld && st_r == ST_IDLE && byte_d[7:4] == 4'h3) |=> (st_r == ST_IDLE && !cal_r.go && $stable(cont_r)))
        else $error("reserved opcode acted");
endmodule : ascd_decoder

// >>> test/ascd_host_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module ascd_host_model
(
    input wire logic clk_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic din_o
);
    // Half period of eight system cycles gives the 80 ns serial clock.
    localparam int HALF = 8;

    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        din_o = 1'b1;
    end

    // One byte per frame, MSB first; data only changes while the serial clock is low.
    task automatic send(input logic [7:0] b);
        cs_n_o = 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            din_o = b[i];
            repeat (HALF) @(negedge clk_i);
            sclk_o = 1'b1;
            repeat (HALF) @(negedge clk_i);
            sclk_o = 1'b0;
        end
        repeat (HALF) @(negedge clk_i);
        // Serial clock stays low between frames, so a sleeping device sees no edges.
        cs_n_o = 1'b1;
        // A released line shows the inverse of the last bit, so a stale value is never mistaken for data.
        din_o = ~b[0];
        repeat (HALF) @(negedge clk_i);
    endtask : send
endmodule : ascd_host_model

// >>> test/ascd_decoder_tb.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module ascd_decoder_tb;
    import ascd_pkg::*;
    logic clk = 1'b0;
    logic srst, sclk, cs_n, din, bank_we, cal_done, chk_vld, sync, sleep, cont, cfg_rst, busy;
    logic [6:0] waddr;
    logic [7:0] wdata, csum, exp_sum;
    ascd_cal_t cal_req, last_cal;
    int bad_count = 0;
    int checked = 0;
    int cyc = 0;
    int n_go = 0;
    int n_rst = 0;
    int n_vld = 0;

    always #2.5 clk = ~clk;

    ascd_host_model host (.clk_i(clk), .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));

    ascd_decoder dut (.clk_i(clk), .srst_i(srst), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
        .bank_we_i(bank_we), .bank_waddr_i(waddr), .bank_wdata_i(wdata), .cal_done_i(cal_done),
        .cal_req_o(cal_req), .checksum_o(csum), .checksum_vld_o(chk_vld), .sync_o(sync),
        .sleep_o(sleep), .cont_mode_o(cont), .cfg_reset_o(cfg_rst), .cal_busy_o(busy));

    ////////////////////////////////////////////////////////////////////////////////
    // Pulses last one cycle, so they are counted here rather than polled by the scenarios.
    always @(posedge clk)
    begin
        cyc++;
        if (cal_req.go === 1'b1)
        begin
            n_go++;
            last_cal = cal_req;
        end
        if (cfg_rst === 1'b1) n_rst++;
        if (chk_vld === 1'b1) n_vld++;
        if (cyc == 20000)
        begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic end_of_test();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////////////////////////////////////////////
    // Values wrap the 8-bit sum many times and set every bit position of the stored bytes.
    task automatic t_fill();
        exp_sum = 8'h00;
        for (int a = 0; a < 128; a++)
        begin
            bank_we = 1'b1;
            waddr = 7'(a);
            wdata = 8'(8'hc3 + a * 37);
            exp_sum = exp_sum + wdata;
            @(negedge clk);
        end
        bank_we = 1'b0;
    endtask : t_fill

    task automatic t_checksum();
        int n0 = n_vld;
        host.send(OP_ALL_BANK_CSUM);
        for (int i = 0; i < 300 && n_vld == n0; i++) @(negedge clk);
        chk(8'(n_vld - n0), 8'h01, "checksum done count");
        chk(csum, exp_sum, "all bank checksum");
    endtask : t_checksum

    task automatic t_cal();
        logic [7:0] codes [5] = '{OP_SELF_CAL_BOTH, OP_SELF_CAL_OFFSET, OP_SELF_CAL_GAIN,
            OP_SYSTEM_CAL_OFFSET, OP_SYSTEM_CAL_GAIN};
        logic [2:0] want [5] = '{3'b110, 3'b100, 3'b010, 3'b101, 3'b011};
        int n0;
        for (int k = 0; k < 5; k++)
        begin
            n0 = n_go;
            host.send(codes[k]);
            chk(8'(n_go - n0), 8'h01, "cal request count");
            chk(8'(last_cal[2:0]), 8'(want[k]), "cal kind");
            chk({7'h00, busy}, 8'h01, "cal busy set");
            cal_done = 1'b1;
            @(negedge clk);
            cal_done = 1'b0;
            @(negedge clk);
            chk({7'h00, busy}, 8'h00, "cal busy cleared");
        end
    endtask : t_cal

    task automatic t_sync();
        host.send(OP_DSYNC);
        chk({7'h00, sync}, 8'h01, "sync raised");
        host.send(8'hff);
        chk({7'h00, sync}, 8'h00, "sync ends at serial edge");
    endtask : t_sync

    task automatic t_sleep();
        host.send(OP_SLEEP);
        repeat (50) @(negedge clk);
        chk({7'h00, sleep}, 8'h01, "sleep held");
        host.send(OP_WAKEUP);
        chk({7'h00, sleep}, 8'h00, "woken");
    endtask : t_sleep

    task automatic t_reset_cmd();
        int n0;
        host.send(OP_RDATAC);
        chk({7'h00, cont}, 8'h01, "continuous on");
        host.send(OP_STOPC);
        chk({7'h00, cont}, 8'h00, "continuous stopped");
        host.send(OP_RDATAC);
        n0 = n_rst;
        host.send(OP_RESET);
        chk(8'(n_rst - n0), 8'h01, "config reset pulse");
        chk({7'h00, cont}, 8'h00, "continuous ended by reset");
        t_checksum();
    endtask : t_reset_cmd

    task automatic t_reserved();
        logic [7:0] codes [15] = '{8'h00, 8'h02, 8'h28, 8'h30, 8'h49, 8'h70, 8'h80, 8'h90,
            8'ha0, 8'hbf, 8'hd9, 8'he9, 8'hf5, 8'hfa, 8'hff};
        int n0;
        // Continuous mode stays on, so a reserved code that wrongly clears it is caught.
        host.send(OP_RDATAC);
        for (int k = 0; k < 15; k++)
        begin
            n0 = n_go + n_rst + n_vld;
            host.send(codes[k]);
            repeat (140) @(negedge clk);
            chk(8'(n_go + n_rst + n_vld - n0), 8'h00, "reserved code pulses");
            chk({4'h0, sync, sleep, cont, busy}, 8'h02, "reserved code levels");
        end
    endtask : t_reserved

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        srst = 1'b1;
        bank_we = 1'b0;
        waddr = 7'h00;
        wdata = 8'h00;
        cal_done = 1'b0;
        repeat (12) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        chk({3'h0, sync, sleep, cont, busy, cfg_rst}, 8'h00, "outputs after reset");
        t_fill();
        t_checksum();
        t_cal();
        t_sync();
        t_sleep();
        t_reset_cmd();
        t_reserved();
        end_of_test();
    end
endmodule : ascd_decoder_tb
